// [design/ncb_cycle.sv]
// one flash bus cycle: command, address, data write or data read
`timescale 1ns/1ps
`default_nettype none
module ncb_cycle (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire ncb_pkg::ncb_kind_t kind,
   input wire logic [7:0] wbyte,
   input wire logic [7:0] io_in,
   output logic busy,
   output logic done,
   output logic [7:0] rbyte,
   output logic cle,
   output logic ale,
   output logic we_n,
   output logic re_n,
   output logic [7:0] io_out,
   output logic io_oe
);
   typedef enum logic [1:0] {P_IDLE, P_SETUP, P_LOW, P_HIGH} ncb_phase_t;
   localparam logic [3:0] LOW_LAST = 4'(ncb_pkg::STROBE_LOW_CYC - 1);
   localparam logic [3:0] HIGH_LAST = 4'(ncb_pkg::STROBE_HIGH_CYC - 1);

   ncb_phase_t phase;
   logic [3:0] cnt;
   logic is_rd;

   wire low_end = (phase == P_LOW) && (cnt == LOW_LAST);
   wire high_end = (phase == P_HIGH) && (cnt == HIGH_LAST);

   assign busy = (phase != P_IDLE);

   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= P_IDLE;
         cnt <= 4'h0;
         is_rd <= 1'b0;
         done <= 1'b0;
         rbyte <= 8'h00;
         cle <= 1'b0;
         ale <= 1'b0;
         we_n <= 1'b1;
         re_n <= 1'b1;
         io_out <= 8'h00;
         io_oe <= 1'b0;
      end else begin
         done <= high_end;
         unique case (phase)
            P_IDLE: begin
               if (start) begin
                  // latches and data settle one cycle before the strobe
                  phase <= P_SETUP;
                  is_rd <= (kind == ncb_pkg::K_RD);
                  cle <= (kind == ncb_pkg::K_CMD);
                  ale <= (kind == ncb_pkg::K_ADDR);
                  io_oe <= (kind != ncb_pkg::K_RD);
                  io_out <= wbyte;
               end
            end
            P_SETUP: begin
               phase <= P_LOW;
               cnt <= 4'h0;
               we_n <= is_rd;
               re_n <= !is_rd;
            end
            P_LOW: begin
               cnt <= cnt + 4'h1;
               if (low_end) begin
                  phase <= P_HIGH;
                  cnt <= 4'h0;
                  we_n <= 1'b1;
                  re_n <= 1'b1;
                  if (is_rd) begin
                     rbyte <= io_in;
                  end
               end
            end
            P_HIGH: begin
               cnt <= cnt + 4'h1;
               if (high_end) begin
                  // write data held through the high phase for hold time
                  phase <= P_IDLE;
                  cle <= 1'b0;
                  ale <= 1'b0;
                  io_oe <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [design/ncb_host.sv]
// flash host: copy-back, identification, status and ecc status sequencer
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] copy-back read: 00h, five address cycles of source, 35h loads page.
// [R2] copy program: 85h with destination address, programming starts at 10h.
// [R3] optional 85h, new column and patch bytes before the 10h confirm.
// [R4] destination must share source block parity; otherwise refused.
// [R5] busy is seen on the ready pin or status bit 7.
// [R6] program pass/fail taken from status bit 1 after completion.
// [R7] after 70h, status is reread on every strobe without new command.
// [R8] after copy-back read, status and ecc status are read out.
// [R9] identification gives five bytes in order.
// [R10] byte three: chip count, cell levels, upper nibble 1001.
// [R11] byte four: page size, block size, io width.
// [R12] byte five: plane groups and ecc engine flag.
// [R13] status byte comes on each read strobe after 70h.
// [R14] status bit 1: program fail, or uncorrectable after read.
// [R15] status bit 4: rewrite advised after a read.
// [R16] status bits 6 and 7 high mean ready.
// [R17] status bit 8 high means not write-protected.
// [R18] bit 1 only trusted once the device is ready.
// [R19] status accepted during a read, showing ready and ecc result.
// [R20] up to eight bit errors per sector are corrected.
// [R21] ecc byte: sector id high nibble, error status low nibble.
// [R22] ecc codes: 0 none, 1..8 corrected, F uncorrectable.
// [R23] sector ids 0..3 name sectors one to four, others reserved.
// [R24] while busy only status read commands are issued.
// [R25] identification: 90h, one address cycle, then successive reads.
module ncb_host (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [5:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic CE_N,
   output logic CLE,
   output logic ALE,
   output logic WE_N,
   output logic RE_N,
   output logic WP_N,
   output logic [7:0] IO_OUT,
   output logic IO_OE,
   input wire logic [7:0] IO_IN,
   input wire logic RB_N
);
   typedef enum logic [3:0] {
      S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT, S_POLL_CMD, S_POLL_RD,
      S_ECC_CMD, S_ECC_RD, S_ID_RD, S_PATCH_CMD, S_PATCH_COL,
      S_PATCH_DAT, S_CONFIRM, S_END
   } ncb_state_t;

   localparam logic [3:0] SETTLE_LAST = 4'(ncb_pkg::BUSY_SETTLE_CYC - 1);

   ncb_state_t state, next_state;
   logic [2:0] op, idx, next_idx;
   logic pending;
   logic [3:0] wait_cnt;
   logic [23:0] src_row, dst_row;
   logic [15:0] patch_col;
   logic [2:0] patch_cnt;
   logic [31:0] patch_data;
   logic [7:0] last_status;
   logic done_flag, plane_err, fail_flag, rewrite_flag;
   logic [7:0] id_byte [0:4];
   logic [3:0] ecc_sec [0:3];
   logic ecc_bad;

   // ----------------------------------------------------------------
   // cycle engine
   // ----------------------------------------------------------------
   logic cyc_busy, cyc_done;
   logic [7:0] cyc_rbyte;
   ncb_pkg::ncb_kind_t cur_kind;
   logic [7:0] cur_byte;

   wire issuing = (state != S_IDLE) && (state != S_WAIT)
      && (state != S_END);
   wire launch = issuing && !pending && !cyc_busy;

   ncb_cycle u_cycle (
      .clk(REF_CLK),
      .rst(RST),
      .start(launch),
      .kind(cur_kind),
      .wbyte(cur_byte),
      .io_in(IO_IN),
      .busy(cyc_busy),
      .done(cyc_done),
      .rbyte(cyc_rbyte),
      .cle(CLE),
      .ale(ALE),
      .we_n(WE_N),
      .re_n(RE_N),
      .io_out(IO_OUT),
      .io_oe(IO_OE)
   );

   // ----------------------------------------------------------------
   // byte selection
   // ----------------------------------------------------------------
   wire is_prog = (op == ncb_pkg::OP_CB_PROG);
   wire [23:0] row = is_prog ? dst_row : src_row;
   wire [7:0] row_byte = (idx == 3'h2) ? row[7:0]
      : (idx == 3'h3) ? row[15:8] : row[23:16];
   wire [7:0] addr_byte = (op == ncb_pkg::OP_READ_ID) ? ncb_pkg::ID_ADDR
      : (idx < 3'h2) ? ncb_pkg::COL_ZERO : row_byte;
   wire [31:0] patch_sh = patch_data >> {idx[1:0], 3'b000};
   wire [7:0] cmd1_byte =
      (op == ncb_pkg::OP_CB_READ) ? ncb_pkg::CMD_READ_SETUP // [R1]
      : is_prog ? ncb_pkg::CMD_COPY_INPUT // [R2]
      : (op == ncb_pkg::OP_READ_ID) ? ncb_pkg::CMD_READ_ID // [R25]
      : (op == ncb_pkg::OP_STATUS) ? ncb_pkg::CMD_STATUS
      : ncb_pkg::CMD_ECC_STATUS;

   always_comb begin
      cur_kind = ncb_pkg::K_CMD;
      cur_byte = 8'h00;
      unique case (state)
         S_CMD1: cur_byte = cmd1_byte;
         S_ADDR: begin
            cur_kind = ncb_pkg::K_ADDR;
            cur_byte = addr_byte;
         end
         S_CMD2: cur_byte = ncb_pkg::CMD_COPY_READ; // [R1]
         S_POLL_CMD: cur_byte = ncb_pkg::CMD_STATUS; // [R24]
         S_ECC_CMD: cur_byte = ncb_pkg::CMD_ECC_STATUS; // [R8]
         S_PATCH_CMD: cur_byte = ncb_pkg::CMD_COPY_INPUT; // [R3]
         S_PATCH_COL: begin
            cur_kind = ncb_pkg::K_ADDR;
            cur_byte = (idx == 3'h0) ? patch_col[7:0] : patch_col[15:8];
         end
         S_PATCH_DAT: begin
            cur_kind = ncb_pkg::K_WR;
            cur_byte = patch_sh[7:0]; // [R3]
         end
         S_CONFIRM: cur_byte = ncb_pkg::CMD_PROG_CONFIRM; // [R2]
         S_POLL_RD, S_ECC_RD, S_ID_RD: cur_kind = ncb_pkg::K_RD;
         S_IDLE, S_WAIT, S_END: cur_kind = ncb_pkg::K_CMD;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   wire [2:0] wr_op = REG_WDATA[2:0];
   wire op_valid = (wr_op >= ncb_pkg::OP_CB_READ)
      && (wr_op <= ncb_pkg::OP_ECC);
   wire cmd_wr = REG_WR && (REG_ADDR == ncb_pkg::REG_CMD)
      && (state == S_IDLE) && op_valid;
   wire same_group = (src_row[ncb_pkg::ROW_BLOCK_LSB]
      == dst_row[ncb_pkg::ROW_BLOCK_LSB]);
   wire group_bad = (wr_op == ncb_pkg::OP_CB_PROG) && !same_group; // [R4]
   wire start = cmd_wr && !group_bad;
   // ready needs both ready bits; the pin is reported but not required
   wire rd_ready = cyc_rbyte[ncb_pkg::ST_READY_HI]
      && cyc_rbyte[ncb_pkg::ST_READY_LO]; // [R5] [R16]
   wire addr_last = (op == ncb_pkg::OP_READ_ID) ? (idx == 3'h0)
      : (idx == ncb_pkg::ADDR_LAST);
   wire [2:0] patch_last = patch_cnt - 3'h1;

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: if (start) next_state = S_CMD1;
         S_CMD1: begin
            if (cyc_done) begin
               if (op == ncb_pkg::OP_STATUS) next_state = S_POLL_RD;
               else if (op == ncb_pkg::OP_ECC) next_state = S_ECC_RD;
               else next_state = S_ADDR;
            end
         end
         S_ADDR: begin
            if (cyc_done && addr_last) begin
               if (op == ncb_pkg::OP_READ_ID) next_state = S_ID_RD;
               else if (!is_prog) next_state = S_CMD2;
               else if (patch_cnt != 3'h0) next_state = S_PATCH_CMD;
               else next_state = S_CONFIRM;
            end
         end
         S_CMD2: if (cyc_done) next_state = S_WAIT;
         S_WAIT: if (wait_cnt == 4'h0) next_state = S_POLL_CMD;
         S_POLL_CMD: if (cyc_done) next_state = S_POLL_RD;
         S_POLL_RD: begin
            // keep strobing: device stays in status mode [R7] [R13]
            if (cyc_done && (rd_ready || op == ncb_pkg::OP_STATUS)) begin
               next_state = (op == ncb_pkg::OP_CB_READ) ? S_ECC_CMD
                  : S_END; // [R8]
            end
         end
         S_ECC_CMD: if (cyc_done) next_state = S_ECC_RD;
         S_ECC_RD: begin
            if (cyc_done && idx == ncb_pkg::ECC_LAST) next_state = S_END;
         end
         S_ID_RD: begin
            if (cyc_done && idx == ncb_pkg::ID_LAST) next_state = S_END; // [R9]
         end
         S_PATCH_CMD: if (cyc_done) next_state = S_PATCH_COL;
         S_PATCH_COL: begin
            if (cyc_done && idx == ncb_pkg::COL_LAST) begin
               next_state = S_PATCH_DAT;
            end
         end
         S_PATCH_DAT: begin
            if (cyc_done && idx == patch_last) next_state = S_CONFIRM;
         end
         S_CONFIRM: if (cyc_done) next_state = S_WAIT;
         S_END: next_state = S_IDLE;
      endcase
   end

   assign next_idx = (next_state != state) ? 3'h0
      : cyc_done ? idx + 3'h1 : idx;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         idx <= 3'h0;
         pending <= 1'b0;
         wait_cnt <= 4'h0;
         op <= 3'h0;
         CE_N <= 1'b1;
      end else begin
         state <= next_state;
         idx <= next_idx;
         pending <= launch || (pending && !cyc_done);
         CE_N <= (next_state == S_IDLE);
         if (start) op <= wr_op;
         if (state != S_WAIT) wait_cnt <= SETTLE_LAST;
         else wait_cnt <= wait_cnt - 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // results
   // ----------------------------------------------------------------
   wire rd_take = cyc_done && (state == S_POLL_RD);
   wire ecc_take = cyc_done && (state == S_ECC_RD);
   wire [3:0] ecc_code = cyc_rbyte[3:0];
   wire ecc_code_bad = (ecc_code > ncb_pkg::ECC_MAX_CORR)
      && (ecc_code != ncb_pkg::ECC_UNCORR); // [R20] [R22]

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         last_status <= 8'h00;
         fail_flag <= 1'b0;
         rewrite_flag <= 1'b0;
         ecc_bad <= 1'b0;
         done_flag <= 1'b0;
         plane_err <= 1'b0;
      end else begin
         if (start) done_flag <= 1'b0;
         if (state == S_END) done_flag <= 1'b1;
         if (cmd_wr) plane_err <= group_bad; // [R4]
         if (start) ecc_bad <= 1'b0;
         if (rd_take) begin
            last_status <= cyc_rbyte; // [R13] [R17]
            if (rd_ready) begin
               fail_flag <= cyc_rbyte[ncb_pkg::ST_FAIL]; // [R6] [R14] [R18]
               rewrite_flag <= cyc_rbyte[ncb_pkg::ST_REWRITE]
                  && (op != ncb_pkg::OP_CB_PROG); // [R15] [R19]
            end
         end
         if (ecc_take && ecc_code_bad) ecc_bad <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         for (int i = 0; i < 4; i++) ecc_sec[i] <= 4'h0;
         for (int i = 0; i < 5; i++) id_byte[i] <= 8'h00;
      end else begin
         if (ecc_take && cyc_rbyte[7:4] < ncb_pkg::SECTORS) begin
            ecc_sec[cyc_rbyte[5:4]] <= ecc_code; // [R21] [R23]
         end
         if (cyc_done && state == S_ID_RD) begin
            id_byte[idx] <= cyc_rbyte; // [R9] [R25]
         end
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   logic [3:0] chips, page_kb, planes;
   logic [4:0] levels;
   logic [9:0] block_kb;
   logic x16, ecc_engine, id3_ok;

   ncb_id_decode u_dec (
      .id3(id_byte[2]),
      .id4(id_byte[3]),
      .id5(id_byte[4]),
      .chips(chips),
      .levels(levels),
      .page_kb(page_kb),
      .block_kb(block_kb),
      .x16(x16),
      .planes(planes),
      .ecc_engine(ecc_engine),
      .id3_ok(id3_ok)
   );

   wire any_uncorr = (ecc_sec[0] == ncb_pkg::ECC_UNCORR)
      || (ecc_sec[1] == ncb_pkg::ECC_UNCORR)
      || (ecc_sec[2] == ncb_pkg::ECC_UNCORR)
      || (ecc_sec[3] == ncb_pkg::ECC_UNCORR); // [R22]
   wire [31:0] st_word = {16'h0000, last_status, 1'b0, WP_N, RB_N,
      rewrite_flag, fail_flag, plane_err, done_flag, state != S_IDLE};
   wire [31:0] rd_mux =
      (REG_ADDR == ncb_pkg::REG_CMD) ? {29'h0000_0000, op}
      : (REG_ADDR == ncb_pkg::REG_SRC_ROW) ? {8'h00, src_row}
      : (REG_ADDR == ncb_pkg::REG_DST_ROW) ? {8'h00, dst_row}
      : (REG_ADDR == ncb_pkg::REG_PATCH) ? {13'h0000, patch_cnt, patch_col}
      : (REG_ADDR == ncb_pkg::REG_PATCH_DATA) ? patch_data
      : (REG_ADDR == ncb_pkg::REG_STATUS) ? st_word
      : (REG_ADDR == ncb_pkg::REG_ID_LO) ?
         {id_byte[3], id_byte[2], id_byte[1], id_byte[0]}
      : (REG_ADDR == ncb_pkg::REG_ID_HI) ?
         {x16, block_kb, page_kb, levels, chips, id_byte[4]}
      : (REG_ADDR == ncb_pkg::REG_ID_X) ?
         {26'h000_0000, id3_ok, ecc_engine, planes}
      : (REG_ADDR == ncb_pkg::REG_ECC) ?
         {14'h0000, ecc_bad, any_uncorr,
          ecc_sec[3], ecc_sec[2], ecc_sec[1], ecc_sec[0]}
      : (REG_ADDR == ncb_pkg::REG_CTRL) ? {31'h0000_0000, WP_N}
      : 32'h0000_0000;
   // a zero count is no patch; counts past four are clipped
   wire [2:0] wr_cnt = (REG_WDATA[18:16] > ncb_pkg::PATCH_MAX)
      ? ncb_pkg::PATCH_MAX : REG_WDATA[18:16];
   // row and patch registers are frozen while a sequence runs
   wire cfg_wr = REG_WR && (state == S_IDLE);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         REG_RDATA <= 32'h0000_0000;
         src_row <= 24'h00_0000;
         dst_row <= 24'h00_0000;
         patch_col <= 16'h0000;
         patch_cnt <= 3'h0;
         patch_data <= 32'h0000_0000;
         WP_N <= ncb_pkg::RST_WP_N;
      end else begin
         REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
         if (cfg_wr && REG_ADDR == ncb_pkg::REG_SRC_ROW) begin
            src_row <= REG_WDATA[23:0];
         end
         if (cfg_wr && REG_ADDR == ncb_pkg::REG_DST_ROW) begin
            dst_row <= REG_WDATA[23:0];
         end
         if (cfg_wr && REG_ADDR == ncb_pkg::REG_PATCH) begin
            patch_col <= REG_WDATA[15:0];
            patch_cnt <= wr_cnt;
         end
         if (cfg_wr && REG_ADDR == ncb_pkg::REG_PATCH_DATA) begin
            patch_data <= REG_WDATA;
         end
         if (REG_WR && REG_ADDR == ncb_pkg::REG_CTRL) WP_N <= REG_WDATA[0];
      end
   end
endmodule
`default_nettype wire

// [design/ncb_id_decode.sv]
// decodes the feature fields of identification bytes three to five
`timescale 1ns/1ps
`default_nettype none
module ncb_id_decode (
   input wire logic [7:0] id3,
   input wire logic [7:0] id4,
   input wire logic [7:0] id5,
   output logic [3:0] chips,
   output logic [4:0] levels,
   output logic [3:0] page_kb,
   output logic [9:0] block_kb,
   output logic x16,
   output logic [3:0] planes,
   output logic ecc_engine,
   output logic id3_ok
);
   assign chips = ncb_pkg::pow2(id3[1:0]); // [R10]
   assign levels = {ncb_pkg::pow2(id3[3:2]), 1'b0}; // [R10]
   assign id3_ok = (id3[7:4] == ncb_pkg::ID3_MARK); // [R10]
   assign page_kb = ncb_pkg::pow2(id4[1:0]); // [R11]
   assign block_kb = {ncb_pkg::pow2(id4[5:4]), 6'b00_0000}; // [R11]
   assign x16 = id4[6]; // [R11]
   assign planes = ncb_pkg::pow2(id5[3:2]); // [R12]
   assign ecc_engine = id5[7]; // [R12]
endmodule
`default_nettype wire

// [design/ncb_pkg.sv]
// shared constants and types of the flash copy-back / id / status host
package ncb_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 8000;
   localparam int T_STROBE_LOW_NS = 20;
   localparam int T_STROBE_HIGH_NS = 20;
   localparam int T_BUSY_SETTLE_NS = 100;
   localparam int STROBE_LOW_CYC =
      (T_STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_HIGH_CYC =
      (T_STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BUSY_SETTLE_CYC =
      (T_BUSY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ----------------------------------------------------------------
   // flash command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_COPY_READ = 8'h35;
   localparam logic [7:0] CMD_COPY_INPUT = 8'h85;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_ECC_STATUS = 8'h7A;
   localparam logic [7:0] ID_ADDR = 8'h00;
   localparam logic [7:0] COL_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // status byte bits, id fields, ecc codes
   // ----------------------------------------------------------------
   localparam int ST_FAIL = 0;
   localparam int ST_REWRITE = 3;
   localparam int ST_READY_LO = 5;
   localparam int ST_READY_HI = 6;
   localparam int ST_NOT_WP = 7;
   localparam logic [3:0] ID3_MARK = 4'h9;
   localparam logic [3:0] ECC_MAX_CORR = 4'h8;
   localparam logic [3:0] ECC_UNCORR = 4'hF;
   localparam logic [3:0] SECTORS = 4'h4;
   localparam int ROW_BLOCK_LSB = 6;
   localparam logic [2:0] ADDR_LAST = 3'h4;
   localparam logic [2:0] ID_LAST = 3'h4;
   localparam logic [2:0] ECC_LAST = 3'h3;
   localparam logic [2:0] COL_LAST = 3'h1;
   localparam logic [2:0] PATCH_MAX = 3'h4;

   // ----------------------------------------------------------------
   // register map and operations
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_CMD = 6'h00;
   localparam logic [5:0] REG_SRC_ROW = 6'h04;
   localparam logic [5:0] REG_DST_ROW = 6'h08;
   localparam logic [5:0] REG_PATCH = 6'h0C;
   localparam logic [5:0] REG_PATCH_DATA = 6'h10;
   localparam logic [5:0] REG_STATUS = 6'h14;
   localparam logic [5:0] REG_ID_LO = 6'h18;
   localparam logic [5:0] REG_ID_HI = 6'h1C;
   localparam logic [5:0] REG_ID_X = 6'h20;
   localparam logic [5:0] REG_ECC = 6'h24;
   localparam logic [5:0] REG_CTRL = 6'h28;
   localparam logic [2:0] OP_CB_READ = 3'h1;
   localparam logic [2:0] OP_CB_PROG = 3'h2;
   localparam logic [2:0] OP_READ_ID = 3'h3;
   localparam logic [2:0] OP_STATUS = 3'h4;
   localparam logic [2:0] OP_ECC = 3'h5;
   localparam logic RST_WP_N = 1'b0;

   typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} ncb_kind_t;

   // 2-bit size code to count 1, 2, 4, 8
   function automatic logic [3:0] pow2(input logic [1:0] code);
      pow2 = 4'h1 << code;
   endfunction

endpackage

// [testbench/ncb_flash_model.sv]
// behavioural flash device: copy-back buffer, id, status and ecc bytes
`timescale 1ns/1ps
`default_nettype none
module ncb_flash_model #(
   parameter int BUSY_NS = 600,
   parameter logic [7:0] MAKER = 8'h5C, // arbitrary value
   parameter logic [7:0] DEVICE = 8'h3B // arbitrary value
) (
   input wire logic ce_n, cle, ale, we_n, re_n, wp_n, prog_fail, unc,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic rb_n
);
   logic [7:0] pbuf [0:2111];
   logic [7:0] cmd = 8'h00;
   logic [7:0] q;
   logic [15:0] col = 16'h0000;
   logic [23:0] row = 24'h00_0000;
   logic [23:0] prog_row = 24'h00_0000;
   logic [2:0] n = 3'h0;
   logic [2:0] k = 3'h0;
   logic busy = 1'b0;
   logic fail = 1'b0;
   logic rew = 1'b0;
   logic [39:0] id;
   logic [3:0] code;
   assign rb_n = !busy;
   assign id = {8'hF6, 8'h15, 8'h90, DEVICE, MAKER};
   // sector 2 sits at the correction limit, sector 3 may be lost
   assign code = k == 3'h0 ? 4'h0 : k == 3'h1 ? 4'h1 : k == 3'h2 ? 4'h8 :
      unc ? 4'hF : 4'h3;
   always_comb begin
      case (cmd)
         8'h70: q = {wp_n, !busy, !busy, 1'b0, rew, 2'b00, fail};
         8'h90: q = id[k * 8 +: 8];
         8'h7A: q = {1'b0, k, code};
         default: q = pbuf[col];
      endcase
   end
   // released data lines show the inverse, never a stale byte
   assign dout = re_n ? ~q : q;
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         cmd = din;
         n = 3'h0;
         k = 3'h0;
         if (din == 8'h35) begin
            for (int i = 0; i < 2112; i++) pbuf[i] = i[7:0] ^ row[7:0];
            rew = !unc;
            fail = unc;
            busy = 1'b1;
         end
         if (din == 8'h10) begin
            prog_row = row;
            rew = 1'b0;
            fail = prog_fail;
            busy = 1'b1;
         end
      end else if (!ce_n && ale) begin
         if (n < 3'h2) col[n * 8 +: 8] = din;
         else row[(n - 2) * 8 +: 8] = din;
         n = n + 3'h1;
      end else if (!ce_n) begin
         pbuf[col] = din;
         col = col + 16'h0001;
      end
   end
   always @(posedge re_n) k = k + 3'h1;
   always @(posedge busy) #(BUSY_NS) busy = 1'b0;
endmodule
`default_nettype wire

// [testbench/ncb_host_chk.sv]
// pin-level checker for the flash host
`timescale 1ns/1ps
`default_nettype none
module ncb_host_chk (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE_N,
   input wire logic CLE,
   input wire logic ALE,
   input wire logic WE_N,
   input wire logic RE_N,
   input wire logic [7:0] IO_OUT,
   input wire logic IO_OE,
   input wire logic RB_N
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence wr_pulse;
      WE_N ##1 !WE_N [*3] ##1 WE_N;
   endsequence
   sequence rd_pulse;
      !RE_N [*3] ##1 RE_N;
   endsequence
   reset_idle_a: assert property ($fell(RST) |-> CE_N && WE_N && !IO_OE)
      else $error("pins not idle after reset");
   cmd_strobe_a: assert property ($rose(CLE) |-> IO_OE ##0 wr_pulse)
      else $error("bad command cycle");
   addr_strobe_a: assert property ($rose(ALE) |-> IO_OE ##0 wr_pulse)
      else $error("bad address cycle");
   data_hold_a: assert property (!WE_N |-> IO_OE && $stable(IO_OUT))
      else $error("data moved under strobe");
   read_strobe_a: assert property ($fell(RE_N) |-> rd_pulse)
      else $error("bad read strobe");
   read_release_a: assert property (!RE_N |-> !IO_OE && !CLE && !ALE)
      else $error("bus driven during read");
   busy_cmds_a: assert property (!RB_N && $rose(CLE) |-> IO_OUT == 8'h70)
      else $error("command while busy");
   strobe_ce_a: assert property (!WE_N || !RE_N |-> !CE_N)
      else $error("strobe without chip enable");
endmodule
bind ncb_host ncb_host_chk i_chk (.*);
`default_nettype wire

// [testbench/ncb_host_test.sv]
// self-checking bench for the flash host
`timescale 1ns/1ps
`default_nettype none
module ncb_host_test;
   logic REF_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   logic [5:0] REG_ADDR = 6'h00;
   logic [31:0] REG_WDATA = 32'h0000_0000, REG_RDATA, s;
   logic CE_N, CLE, ALE, WE_N, RE_N, WP_N, IO_OE, RB_N;
   logic prog_fail = 1'b0, unc = 1'b0;
   logic [7:0] IO_OUT, IO_IN;
   int n_errors = 0, samples_checked = 0;
   always #4 REF_CLK = ~REF_CLK;
   ncb_host i_dut (.*);
   ncb_flash_model i_mem (.ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N),
      .re_n(RE_N), .wp_n(WP_N), .prog_fail(prog_fail), .unc(unc),
      .din(IO_OUT), .dout(IO_IN), .rb_n(RB_N));
   task automatic print_verdict();
      if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge REF_CLK);
      REG_WR <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [5:0] a);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge REF_CLK);
      REG_RD <= 1'b0;
      #1;
      s = REG_RDATA;
   endtask
   task automatic run(input logic [31:0] op);
      int i;
      wr(6'h00, op);
      @(posedge REF_CLK);
      #1;
      for (i = 0; i < 3000; i++) begin
         rd(6'h14);
         if (s[1:0] === 2'b10) break;
      end
      if (i == 3000) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic t_id();
      wr(6'h28, 32'h0000_0001);
      run(32'h0000_0003);
      rd(6'h18);
      chk(s, {8'h15, 8'h90, i_mem.DEVICE, i_mem.MAKER});
      rd(6'h1C);
      chk(s, {1'b0, 10'h080, 4'h2, 5'h02, 4'h1, 8'hF6});
      rd(6'h20);
      chk(s & 32'h0000_003F, 32'h0000_0032);
   endtask
   task automatic t_copy_read(input logic u);
      unc <= u;
      wr(6'h04, 32'h0000_0041);
      run(32'h0000_0001);
      rd(6'h14);
      chk(s & 32'h0000_FFFF, u ? 32'h0000_E16A : 32'h0000_E872);
      rd(6'h24);
      chk(s & 32'h0003_FFFF, {14'h0000, 1'b0, u, u ? 4'hF : 4'h3,
         12'h810});
   endtask
   task automatic t_copy_prog();
      prog_fail <= 1'b1;
      wr(6'h08, 32'h0000_0143);
      wr(6'h0C, 32'h0002_0830);
      wr(6'h10, 32'h0000_5AA5);
      run(32'h0000_0002);
      chk({8'h00, i_mem.prog_row}, 32'h0000_0143);
      chk({i_mem.pbuf[2096], i_mem.pbuf[2097], i_mem.pbuf[2098], 8'h00},
         {8'hA5, 8'h5A, 8'h32 ^ 8'h41, 8'h00});
      rd(6'h14);
      chk(s & 32'h0000_FFEF, 32'h0000_E16A);
   endtask
   task automatic t_status();
      wr(6'h28, 32'h0000_0000);
      run(32'h0000_0004);
      rd(6'h14);
      chk(s & 32'h0000_FF40, 32'h0000_6100);
   endtask
   task automatic t_plane();
      int bad = 0;
      wr(6'h08, 32'h0000_0180);
      wr(6'h00, 32'h0000_0002);
      repeat (20) begin
         @(posedge REF_CLK);
         bad += int'(CE_N !== 1'b1);
      end
      #1;
      rd(6'h14);
      chk(s & 32'h0000_0005, 32'h0000_0004);
      chk(bad, 32'h0000_0000);
      rd(6'h2C);
      chk(s, 32'h0000_0000);
   endtask
   initial begin
      repeat (8) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      #1;
      t_id();
      t_copy_read(1'b1);
      t_copy_read(1'b0);
      t_copy_prog();
      t_status();
      t_plane();
      print_verdict();
   end
endmodule
`default_nettype wire
